/* File: verilog/lock_cmd_handler.v */
// Purpose: Lock command, invalid-opcode answer and parameter retention
// Assumes: AHB-Lite single word transfers, zero wait states
// Notes:   Legal opcodes other than lock are only forwarded
`timescale 1ns/1ps
`include "lock_cmd_defines.vh"
module lock_cmd_handler (
    input  wire        sys_clk,       // 20 MHz clock
    input  wire        reset,         // Hardware reset, sync, high
    // AHB-Lite slave port
    input  wire        hsel,          // AHB slave select
    input  wire [31:0] haddr,         // AHB address
    input  wire [1:0]  htrans,        // AHB transfer type
    input  wire        hwrite,        // AHB write
    input  wire [2:0]  hsize,         // AHB size
    input  wire [31:0] hwdata,        // AHB write data
    input  wire        hready,        // AHB bus ready
    output reg  [31:0] hrdata,        // AHB read data
    output reg         hreadyout,     // AHB slave ready
    output reg         hresp,         // AHB response, always OKAY
    output reg         irq,           // Level interrupt
    // Command path towards the rest of the controller
    output reg         fwd_cmd_valid, // Legal opcode passed on, pulse
    output reg  [7:0]  fwd_cmd_byte,  // Opcode passed on
    // Settings that a soft reset may keep
    output reg         fifo_disable,  // Queue disabled
    output reg  [3:0]  fifo_level_trigger,   // Queue threshold
    output reg  [7:0]  precomp_start_track,  // Precompensation track
    output reg         host_write_queue_off, // Write queue off
    output reg         host_read_queue_off,  // Read queue off
    output reg         burst_off      // Burst mode off
);
    localparam ST_IDLE    = 2'h0;
    localparam ST_INVALID = 2'h1;
    localparam ST_LOCK    = 2'h2;

    reg  [1:0]  state;
    reg  [7:0]  result_byte;
    reg         keep_params_flag;
    reg         pending_keep;
    reg  [1:0]  irq_status;
    reg  [1:0]  irq_mask;
    reg  [2:0]  size_code;
    reg         wr_pend;
    reg  [7:0]  wr_addr;
    reg  [1:0]  next_state;
    reg  [7:0]  next_result;
    reg         next_pending;
    reg  [31:0] rd_value;
    reg  [1:0]  next_irq_status;
    wire        addr_phase;
    wire        rd_take;
    wire        data_rd;
    wire        data_wr;
    wire        soft_rst;
    wire        lock_done;
    wire [1:0]  events;
    wire [7:0]  main_status_reg;
    wire [13:0] sector_bytes;
    wire [7:0]  cmd;
    wire        cfg_wr;
    wire        mode_wr;
    wire        geom_wr;
    wire        stat_wr;
    wire        mask_wr;

    assign addr_phase = hsel & hready & (htrans == `HTRANS_NONSEQ);
    assign rd_take    = addr_phase & ~hwrite;
    assign data_rd    = rd_take & (haddr[7:0] == `OFS_DATA);
    assign data_wr    = wr_pend & (wr_addr == `OFS_DATA);
    assign soft_rst   = wr_pend & (wr_addr == `OFS_CONTROL)
                        & hwdata[`CTL_SOFT_RESET];
    assign cmd        = hwdata[7:0];
    assign lock_done  = data_rd & (state == ST_LOCK) & ~soft_rst;
    assign events     = {soft_rst, lock_done};
    // Register writes land in the data phase
    assign cfg_wr     = wr_pend & (wr_addr == `OFS_CONFIG);
    assign mode_wr    = wr_pend & (wr_addr == `OFS_MODE);
    assign geom_wr    = wr_pend & (wr_addr == `OFS_GEOMETRY);
    assign stat_wr    = wr_pend & (wr_addr == `OFS_IRQ_STATUS);
    assign mask_wr    = wr_pend & (wr_addr == `OFS_IRQ_MASK);
    // Result pending shows both request and direction set
    assign main_status_reg = {1'b1, (state != ST_IDLE), 1'b0,
                              (state != ST_IDLE), 4'h0};

    sector_size_decode u_sector_size_decode (
        .size_code  (size_code),
        .size_bytes (sector_bytes)
    );

    function legal_other;
        input [7:0] op;
        begin
            case (op[4:0])
                5'h01,
                5'h02,
                5'h03,
                5'h04,
                5'h05,
                5'h06,
                5'h07,
                5'h08,
                5'h09,
                5'h0A,
                5'h0C,
                5'h0D,
                5'h0E,
                5'h0F,
                5'h10,
                5'h11,
                5'h12,
                5'h13,
                5'h16,
                5'h18,
                5'h19,
                5'h1D,
                5'h1E: legal_other = 1'b1;
                default: legal_other = 1'b0;
            endcase
        end
    endfunction

    // Command interpreter
    always @* begin
        next_state   = state;
        next_result  = result_byte;
        next_pending = pending_keep;
        case (state)
            ST_IDLE: begin
                if (data_wr) begin
                    if (cmd[6:0] == `LOCK_OPCODE) begin
                        next_state   = ST_LOCK;
                        next_pending = cmd[7];
                        next_result  = 8'h00;
                        next_result[`LOCK_RESULT_BIT] = cmd[7];
                    end else if (!legal_other(cmd)) begin
                        next_state  = ST_INVALID;
                        next_result = `INVALID_RESULT;
                    end
                end
            end
            ST_INVALID: begin
                if (data_rd) begin
                    next_state = ST_IDLE;
                end
            end
            ST_LOCK: begin
                if (data_rd) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
        if (soft_rst) begin
            next_state = ST_IDLE;
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            state        <= ST_IDLE;
            result_byte  <= 8'h00;
            pending_keep <= 1'b0;
        end else begin
            state        <= next_state;
            result_byte  <= next_result;
            pending_keep <= next_pending;
        end
    end

    // Forward legal non-lock opcodes to the rest of the controller
    always @(posedge sys_clk) begin
        if (reset) begin
            fwd_cmd_valid <= 1'b0;
            fwd_cmd_byte  <= 8'h00;
        end else begin
            fwd_cmd_valid <= data_wr & (state == ST_IDLE)
                             & (cmd[6:0] != `LOCK_OPCODE) & legal_other(cmd);
            if (data_wr & (state == ST_IDLE)) begin
                fwd_cmd_byte <= cmd;
            end
        end
    end

    // Keep flag and retainable parameters
    always @(posedge sys_clk) begin
        if (reset) begin
            keep_params_flag     <= 1'b0;
            fifo_disable         <= `DEF_FIFO_DIS;
            fifo_level_trigger   <= `DEF_LEVEL_TRIG;
            precomp_start_track  <= `DEF_PRECOMP_TRK;
            host_write_queue_off <= `DEF_WR_QOFF;
            host_read_queue_off  <= `DEF_RD_QOFF;
            burst_off            <= `DEF_BURST_OFF;
        end else if (soft_rst) begin
            if (!keep_params_flag) begin
                fifo_disable         <= `DEF_FIFO_DIS;
                fifo_level_trigger   <= `DEF_LEVEL_TRIG;
                precomp_start_track  <= `DEF_PRECOMP_TRK;
                host_write_queue_off <= `DEF_WR_QOFF;
                host_read_queue_off  <= `DEF_RD_QOFF;
                burst_off            <= `DEF_BURST_OFF;
            end
            // Keep flag set: every setting holds
        end else begin
            if (lock_done) begin
                keep_params_flag <= pending_keep;
            end
            if (cfg_wr) begin
                fifo_disable        <= hwdata[`CFG_FIFO_DIS];
                fifo_level_trigger  <= hwdata[`CFG_THR_LSB +: 4];
                precomp_start_track <= hwdata[`CFG_PRE_LSB +: 8];
            end
            if (mode_wr) begin
                host_write_queue_off <= hwdata[`MODE_WR_QOFF];
                host_read_queue_off  <= hwdata[`MODE_RD_QOFF];
                burst_off            <= hwdata[`MODE_BURST_OFF];
            end
        end
    end

    // Geometry: gap byte in [15:8] is accepted and dropped
    always @(posedge sys_clk) begin
        if (reset) begin
            size_code <= `CODE_512;
        end else if (geom_wr) begin
            size_code <= hwdata[2:0];
        end
    end

    // Invalid result is not an event here
    always @* begin
        next_irq_status = irq_status;
        if (stat_wr) begin
            next_irq_status = next_irq_status & ~hwdata[1:0];
        end
        next_irq_status = next_irq_status | events;
    end

    // Interrupt status, set wins over write-one-to-clear
    always @(posedge sys_clk) begin
        if (reset) begin
            irq_status <= 2'h0;
            irq_mask   <= 2'h0;
            irq        <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
            if (mask_wr) begin
                irq_mask <= hwdata[1:0];
            end
            irq <= |(irq_status & irq_mask);
        end
    end

    // Read mux
    always @* begin
        case (haddr[7:0])
            `OFS_DATA:        rd_value = {24'h0, result_byte};
            `OFS_MAIN_STATUS: rd_value = {24'h0, main_status_reg};
            `OFS_CONTROL:     rd_value = {30'h0, keep_params_flag, 1'b0};
            `OFS_CONFIG:      rd_value = {16'h0, precomp_start_track,
                                          fifo_level_trigger, 3'h0,
                                          fifo_disable};
            `OFS_MODE:        rd_value = {29'h0, burst_off,
                                          host_read_queue_off,
                                          host_write_queue_off};
            `OFS_IRQ_STATUS:  rd_value = {30'h0, irq_status};
            `OFS_IRQ_MASK:    rd_value = {30'h0, irq_mask};
            `OFS_GEOMETRY:    rd_value = {2'h0, sector_bytes, 13'h0,
                                          size_code};
            default:          rd_value = 32'h0000_0000;
        endcase
    end

    // AHB-Lite slave: zero wait, read data captured at address phase, write data taken in data phase
    always @(posedge sys_clk) begin
        if (reset) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_pend   <= 1'b0;
            wr_addr   <= 8'h00;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_pend   <= addr_phase & hwrite & (hsize == `HSIZE_WORD);
            if (addr_phase) begin
                wr_addr <= haddr[7:0];
            end
            if (rd_take) begin
                hrdata <= rd_value;
            end
        end
    end
endmodule // lock_cmd_handler

/* File: verilog/lock_cmd_defines.vh */
// Purpose: Shared constants of the lock and invalid-command handler
// Assumes: 32-bit AHB-Lite register window, one word per register
// Notes:   Offsets are byte addresses
`ifndef LOCK_CMD_DEFINES_VH
`define LOCK_CMD_DEFINES_VH

// Register byte offsets
`define OFS_DATA        8'h00
`define OFS_MAIN_STATUS 8'h04
`define OFS_CONTROL     8'h08
`define OFS_CONFIG      8'h0C
`define OFS_MODE        8'h10
`define OFS_IRQ_STATUS  8'h14
`define OFS_IRQ_MASK    8'h18
`define OFS_GEOMETRY    8'h1C

// Command bytes
`define LOCK_OPCODE     7'h14
`define INVALID_RESULT  8'h80
`define LOCK_RESULT_BIT 4

// main_status_reg fields
`define STAT_REQ_BIT    7
`define STAT_DIR_BIT    6
`define STAT_BUSY_BIT   4

// CONFIG fields: [0] fifo_disable, [7:4] threshold, [15:8] precomp track
`define CFG_FIFO_DIS    0
`define CFG_THR_LSB     4
`define CFG_PRE_LSB     8
// MODE fields
`define MODE_WR_QOFF    0
`define MODE_RD_QOFF    1
`define MODE_BURST_OFF  2
// CONTROL fields
`define CTL_SOFT_RESET  0
`define CTL_KEEP        1
// Interrupt events
`define EV_LOCK_DONE    0
`define EV_SOFT_RESET   1

// Defaults of the retainable parameters
`define DEF_FIFO_DIS    1'b1
`define DEF_LEVEL_TRIG  4'h0
`define DEF_PRECOMP_TRK 8'h00
`define DEF_WR_QOFF     1'b0
`define DEF_RD_QOFF     1'b0
`define DEF_BURST_OFF   1'b0

// AHB encodings
`define HTRANS_NONSEQ   2'h2
`define HSIZE_WORD      3'h2

// Recommended format values for the host (the logic uses only CODE_512)
`define GAP_144M        8'h6C
`define LAST_SEC_144M   8'h12
`define GAP_288M        8'h53
`define LAST_SEC_288M   8'h24
`define CODE_512        3'h2

`endif

/* File: verilog/sector_size_decode.v */
// Purpose: Turns a sector size code into a byte count
// Assumes: Codes 0..6 are legal, larger codes give zero
// Notes:   Purely combinational
`timescale 1ns/1ps
module sector_size_decode (
    input  wire [2:0]  size_code,  // Sector size code
    output reg  [13:0] size_bytes  // Bytes per sector
);
    always @* begin
        if (size_code <= 3'h6) begin
            size_bytes = 14'h0080 << size_code;
        end else begin
            size_bytes = 14'h0000;
        end
    end
endmodule // sector_size_decode

/* File: testbench/lock_cmd_props.sv */
// Purpose: Port assertions of the lock command handler
// Assumes: Zero wait state slave, single clock
// Notes:   Bound from the bench top file
`timescale 1ns/1ps
module lock_cmd_props (
    input logic        sys_clk, // clk
    input logic        reset, // rst
    input logic        hsel, // sel
    input logic [31:0] haddr, // addr
    input logic [1:0]  htrans, // trans
    input logic        hwrite, // write
    input logic [2:0]  hsize, // size
    input logic [31:0] hwdata, // wdata
    input logic        hready, // ready in
    input logic [31:0] hrdata, // rdata
    input logic        hreadyout, // ready out
    input logic        hresp, // resp
    input logic        irq, // irq
    input logic        fwd_cmd_valid, // fwd strobe
    input logic [7:0]  fwd_cmd_byte, // fwd byte
    input logic        fifo_disable, // queue off
    input logic [3:0]  fifo_level_trigger, // threshold
    input logic [7:0]  precomp_start_track, // track
    input logic        host_write_queue_off, // wq off
    input logic        host_read_queue_off, // rq off
    input logic        burst_off // burst off
);
    wire  tk = hsel && hready && htrans == 2'h2;
    logic wr_dp;
    logic rd_msr;
    logic wr_cfg;
    logic wr_mode;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    // Marks the data phase of the transfer taken one edge earlier
    always @(posedge sys_clk) begin
        wr_dp  <= tk && hwrite && !reset;
        rd_msr <= tk && !hwrite && haddr[7:0] == 8'h04 && !reset;
        wr_cfg <= tk && hwrite && !reset
                  && (haddr[7:0] == 8'h0C || haddr[7:0] == 8'h08);
        wr_mode <= tk && hwrite && !reset
                   && (haddr[7:0] == 8'h10 || haddr[7:0] == 8'h08);
    end
    sequence s_lock_cmd;
        tk && hwrite && haddr[7:0] == 8'h00 ##1 hwdata[6:0] == 7'h14;
    endsequence
    property p_ready;
        hreadyout && !hresp;
    endproperty
    a_ready: assert property (p_ready) else $error("slave not ready");
    property p_hwdef;
        $fell(reset) |-> !irq && fifo_disable && fifo_level_trigger == 4'h0
            && precomp_start_track == 8'h00 && !host_write_queue_off
            && !host_read_queue_off && !burst_off;
    endproperty
    a_hwdef: assert property (p_hwdef) else $error("reset defaults");
    property p_msr;
        rd_msr |-> hrdata[7] && hrdata[6] == hrdata[4];
    endproperty
    a_msr: assert property (p_msr) else $error("status bits");
    property p_fwd;
        fwd_cmd_valid |-> $past(wr_dp) && fwd_cmd_byte == $past(hwdata[7:0]);
    endproperty
    a_fwd: assert property (p_fwd) else $error("forward cause");
    property p_lock;
        s_lock_cmd |=> !fwd_cmd_valid;
    endproperty
    a_lock: assert property (p_lock) else $error("lock forwarded");
    property p_cfg;
        $changed({fifo_disable, fifo_level_trigger, precomp_start_track})
            |-> $past(wr_cfg) || $past(reset);
    endproperty
    a_cfg: assert property (p_cfg) else $error("config moved");
    property p_mode;
        $changed({host_write_queue_off, host_read_queue_off, burst_off})
            |-> $past(wr_mode) || $past(reset);
    endproperty
    a_mode: assert property (p_mode) else $error("mode moved");
    property p_irq;
        $rose(irq) |-> $past(wr_dp, 2) || $past(tk, 2);
    endproperty
    a_irq: assert property (p_irq) else $error("irq cause");
endmodule // lock_cmd_props

/* File: testbench/host_bus.sv */
// Purpose: Host side bus master issuing single word transfers
// Assumes: Called right after a rising clock edge
// Notes:   Waits on hready without a limit; bench watchdog ends hangs
`timescale 1ns/1ps
module host_bus (
    input  logic        sys_clk, // clk
    input  logic        hready, // ready
    input  logic [31:0] hrdata, // rdata
    output logic        hsel, // sel
    output logic [31:0] haddr, // addr
    output logic [1:0]  htrans, // trans
    output logic        hwrite, // write
    output logic [2:0]  hsize, // size
    output logic [31:0] hwdata // wdata
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    task xfer(input logic w, input logic [7:0] a,
              input logic [31:0] d, output logic [31:0] q);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge sys_clk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= w ? d : ~hwdata;
        do @(posedge sys_clk); while (hready !== 1'b1);
        q = hrdata;
        // Released data must not keep showing the old value
        hwdata <= ~hwdata;
    endtask
endmodule // host_bus

/* File: testbench/fdc_lock_invalid_cmd_handler_tb.sv */
// Purpose: Scenario bench of the lock and invalid-command handler
// Assumes: Zero wait state slave, host model drives the bus
// Notes:   Register offsets as in the shared defines
`timescale 1ns/1ps
`include "lock_cmd_defines.vh"
module fdc_lock_invalid_cmd_handler_tb;
    logic        sys_clk = 1'b0;
    logic        reset;
    int          num_errors = 0;
    int          tests_run = 0;
    wire  [31:0] haddr, hwdata, hrdata;
    wire  [1:0]  htrans;
    wire  [2:0]  hsize;
    wire         hsel, hwrite, hreadyout, hresp, irq, fwd_cmd_valid;
    wire  [7:0]  fwd_cmd_byte, precomp_start_track;
    wire  [3:0]  fifo_level_trigger;
    wire         fifo_disable, host_write_queue_off;
    wire         host_read_queue_off, burst_off;
    host_bus u_host_bus (.sys_clk(sys_clk), .hready(hreadyout),
        .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    lock_cmd_handler u_lock_cmd_handler (.sys_clk(sys_clk), .reset(reset),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
        .fwd_cmd_valid(fwd_cmd_valid), .fwd_cmd_byte(fwd_cmd_byte),
        .fifo_disable(fifo_disable), .fifo_level_trigger(fifo_level_trigger),
        .precomp_start_track(precomp_start_track),
        .host_write_queue_off(host_write_queue_off),
        .host_read_queue_off(host_read_queue_off), .burst_off(burst_off));
    always #25 sys_clk = ~sys_clk;
    task chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        u_host_bus.xfer(1'b1, a, d, q);
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        u_host_bus.xfer(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask
    task give_verdict;
        if (num_errors == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task t_invalid;
        logic [7:0] ops [3];
        ops = '{8'h00, 8'h0B, 8'h1F};
        foreach (ops[i]) begin
            wr(8'h00, {24'h0, ops[i]});
            rdc(8'h04, 32'hD0);
            rdc(8'h14, 32'h0);
            rdc(8'h00, 32'h80);
            rdc(8'h04, 32'h80);
        end
        wr(8'h00, 32'h00);
        wr(8'h00, 32'h94);
        rdc(8'h00, 32'h80);
        rdc(8'h08, 32'h0);
        wr(8'h00, 32'h01);
        @(posedge sys_clk);
        chk({24'h0, fwd_cmd_byte}, 32'h01);
        chk({31'h0, fwd_cmd_valid}, 32'h1);
    endtask
    task t_lock;
        wr(8'h0C, 32'hAB50);
        wr(8'h10, 32'h7);
        wr(8'h00, 32'h94);
        rdc(8'h08, 32'h0);
        rdc(8'h00, 32'h10);
        rdc(8'h08, 32'h2);
        wr(8'h08, 32'h1);
        rdc(8'h0C, 32'hAB50);
        rdc(8'h10, 32'h7);
        chk({28'h0, fifo_level_trigger}, 32'h5);
        wr(8'h00, 32'h14);
        wr(8'h08, 32'h1);
        rdc(8'h08, 32'h2);
        rdc(8'h04, 32'h80);
        wr(8'h00, 32'h14);
        rdc(8'h00, 32'h0);
        wr(8'h08, 32'h1);
        rdc(8'h0C, 32'h1);
        rdc(8'h10, 32'h0);
    endtask
    task t_irq;
        wr(8'h14, 32'h3);
        wr(8'h18, 32'h1);
        wr(8'h00, 32'h94);
        rdc(8'h00, 32'h10);
        repeat (2) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h1);
        wr(8'h14, 32'h1);
        wr(8'h08, 32'h1);
        rdc(8'h14, 32'h2);
        wr(8'h14, 32'h2);
        wr(8'h18, 32'h3);
        wr(8'h00, 32'h1F);
        rdc(8'h00, 32'h80);
        @(posedge sys_clk);
        chk({31'h0, irq}, 32'h0);
        rdc(8'h14, 32'h0);
    endtask
    task t_geom;
        logic [31:0] q;
        for (int c = 1; c < 7; c++) begin
            wr(8'h1C, {16'h0, c[0] ? `GAP_144M : `GAP_288M, 5'h0,
                       c[2:0]});
            u_host_bus.xfer(1'b0, 8'h1C, 32'h0, q);
            chk(q, ((32'h80 << c) << 16) | c);
        end
    endtask
    task t_hwreset;
        wr(8'h20, 32'hFFFFFFFF);
        rdc(8'h20, 32'h0);
        wr(8'h0C, 32'h30);
        wr(8'h10, 32'h4);
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        rdc(8'h08, 32'h0);
        rdc(8'h0C, 32'h1);
        rdc(8'h10, 32'h0);
    endtask
    initial begin
        reset = 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        t_invalid;
        t_lock;
        t_irq;
        t_geom;
        t_hwreset;
        give_verdict;
    end
    initial begin
        #(50 * 4000);
        num_errors++;
        give_verdict;
    end
endmodule // fdc_lock_invalid_cmd_handler_tb
bind lock_cmd_handler lock_cmd_props u_lock_cmd_props (.sys_clk(sys_clk),
    .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
    .fwd_cmd_valid(fwd_cmd_valid), .fwd_cmd_byte(fwd_cmd_byte),
    .fifo_disable(fifo_disable), .fifo_level_trigger(fifo_level_trigger),
    .precomp_start_track(precomp_start_track),
    .host_write_queue_off(host_write_queue_off),
    .host_read_queue_off(host_read_queue_off), .burst_off(burst_off));
